// ---- rtl/cit_core_timing.sv ----
// issue timing and interlock control for a five-stage integer core
`timescale 1ns/1ns
`include "cit_defines.svh"
module cit_core_timing #(
	parameter int REG_COUNT = 16
) (
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              srst,
	// decode stage
	input  wire logic              dec_valid,
	input  wire cit_pkg::cit_instr_t dec_instr,
	input  wire cit_pkg::cit_next_t  dec_next,
	input  wire logic [31:0]       mul_operand,
	// memory side status
	input  wire logic              mem_wait,
	// control outputs
	output logic                   dec_accept,
	output logic                   fetch_en,
	output logic                   interlock,
	output cit_pkg::cit_exec_t     exec_ctl,
	output logic [3:0]             mul_reg_sel,
	output logic [7:0]             instr_cycles
);
	import cit_pkg::*;

	initial begin
		if (REG_COUNT != 16) begin
			$error("cit_core_timing: REG_COUNT must be 16");
		end
	end

	//--------------------------------------------------------------
	// state machine
	//--------------------------------------------------------------
	typedef enum logic [1:0] {
		CIT_IDLE = 2'b00,
		CIT_BUSY = 2'b01,
		CIT_LOCK = 2'b11
	} cit_state_t;

	cit_state_t  state;
	logic [7:0]  remain;      // cycles still owed by the issuing instr
	logic [7:0]  lock_left;   // interlock cycles still owed
	logic [15:0] xfer_list;   // registers still to transfer
	logic        xfer_store;
	logic        xfer_first;

	// lowest set bit in a register list
	function automatic logic [3:0] cit_lowest(input logic [15:0] l);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (l[i]) begin
				r = i[3:0];
			end
		end
		return r;
	endfunction : cit_lowest

	// highest set bit in a register list
	function automatic logic [3:0] cit_highest(input logic [15:0] l);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (l[i]) begin
				r = i[3:0];
			end
		end
		return r;
	endfunction : cit_highest

	// population count of a register list
	function automatic logic [4:0] cit_count(input logic [15:0] l);
		logic [4:0] c;
		c = 5'h0;
		for (int i = 0; i < 16; i++) begin
			c = c + {4'h0, l[i]};
		end
		return c;
	endfunction : cit_count

	//--------------------------------------------------------------
	// multiply early termination
	//--------------------------------------------------------------
	logic [3:0] next_mul_m;
	logic       sgn_mode;

	// operand register select from the instruction encoding
	always_comb begin
		if (dec_instr.compressed) begin
			mul_reg_sel = {1'b0, dec_instr.instr[`CIT_MULREG_C_HI:
				`CIT_MULREG_C_LO]};
		end else begin
			mul_reg_sel = dec_instr.instr[`CIT_MULREG_HI:
				`CIT_MULREG_LO];
		end
	end

	// m from how many upper bytes are pure sign or zero; only zero bytes count for unsigned long
	always_comb begin
		sgn_mode = (dec_instr.op != CIT_UNSIGNED_LONG);
		if (sgn_mode) begin
			if (&mul_operand[31:8] || ~|mul_operand[31:8]) begin
				next_mul_m = 4'h1;
			end else if (&mul_operand[31:16] || ~|mul_operand[31:16]) begin
				next_mul_m = 4'h2;
			end else if (&mul_operand[31:24] || ~|mul_operand[31:24]) begin
				next_mul_m = 4'h3;
			end else begin
				next_mul_m = 4'h4;
			end
		end else begin
			if (~|mul_operand[31:8]) begin
				next_mul_m = 4'h1;
			end else if (~|mul_operand[31:16]) begin
				next_mul_m = 4'h2;
			end else if (~|mul_operand[31:24]) begin
				next_mul_m = 4'h3;
			end else begin
				next_mul_m = 4'h4;
			end
		end
	end

	//--------------------------------------------------------------
	// cycle count and interlock length for the decoded instruction
	//--------------------------------------------------------------
	logic [7:0] next_cycles;
	logic [7:0] next_lock;
	logic [4:0] list_n;
	logic       uses_dest;
	logic       uses_last;
	logic [3:0] last_reg;

	always_comb begin
		list_n    = cit_count(dec_instr.reg_list);
		last_reg  = cit_highest(dec_instr.reg_list);
		uses_dest = dec_next.valid && dec_next.src_mask[dec_instr.dest_reg];
		uses_last = dec_next.valid && dec_next.src_mask[last_reg];
		next_lock = 8'h0;
		case (dec_instr.op)
			CIT_DATA_OP: begin
				next_cycles = dec_instr.reg_shift ? 8'(`CIT_DP_REGSH_CYC)
					: 8'(`CIT_DP_CYC);
			end
			CIT_SINGLE_LOAD: begin
				if (dec_instr.dest_pc) begin
					next_cycles = 8'(`CIT_LD_PC_CYC);
				end else if (uses_dest && dec_instr.narrow) begin
					next_cycles = 8'(`CIT_LD_ROT_CYC);
					next_lock   = 8'(`CIT_LD_ROT_CYC - `CIT_LD_CYC);
				end else if (uses_dest) begin
					next_cycles = 8'(`CIT_LD_USE_CYC);
					next_lock   = 8'(`CIT_LD_USE_CYC - `CIT_LD_CYC);
				end else begin
					next_cycles = 8'(`CIT_LD_CYC);
				end
			end
			CIT_SINGLE_STORE: begin
				next_cycles = 8'(`CIT_LD_CYC);
			end
			CIT_MULTI_LOAD: begin
				if (dec_instr.reg_list[15]) begin
					next_cycles = 8'(list_n) + 8'(`CIT_LDM_PC_EXTRA);
				end else if (list_n == 5'h1) begin
					next_cycles = 8'(`CIT_LDM1_CYC);
				end else begin
					next_cycles = 8'(list_n);
				end
				// issue waits for the final fetch, one more if last used
				if (uses_last && !dec_instr.reg_list[15]) begin
					next_cycles = next_cycles + 8'h1;
					next_lock   = 8'h1;
				end
			end
			CIT_MULTI_STORE: begin
				next_cycles = (list_n > 5'h1) ? 8'(list_n)
					: 8'(`CIT_LDM1_CYC);
			end
			CIT_ATOMIC_SWAP: begin
				if (uses_dest && dec_instr.narrow) begin
					next_cycles = 8'(`CIT_SWP_USE_CYC);
					next_lock   = 8'h1;
				end else begin
					next_cycles = 8'(`CIT_SWP_CYC);
				end
			end
			CIT_BRANCH_OPS, CIT_SOFTWARE_TRAP: begin
				next_cycles = 8'(`CIT_BR_CYC);
			end
			CIT_COPROC_DATA_OP, CIT_CORE_TO_COPROC: begin
				next_cycles = 8'(dec_instr.busy) + 8'h1;
			end
			CIT_COPROC_LDST: begin
				next_cycles = 8'(dec_instr.busy) + 8'(dec_instr.words);
			end
			CIT_COPROC_TO_CORE: begin
				next_cycles = 8'(dec_instr.busy) + 8'h1;
				if (uses_dest) begin
					next_cycles = next_cycles + 8'(`CIT_MRC_USE_EXTRA);
					next_lock   = 8'(`CIT_MRC_USE_EXTRA);
				end
			end
			CIT_SHORT_MULTIPLY: begin
				next_cycles = 8'(`CIT_MUL_BASE) + 8'(next_mul_m);
			end
			CIT_SIGNED_LONG, CIT_UNSIGNED_LONG: begin
				next_cycles = 8'(`CIT_MULL_BASE) + 8'(next_mul_m);
			end
			default: begin
				next_cycles = 8'(`CIT_DP_CYC);
			end
		endcase
	end

	//--------------------------------------------------------------
	// sequencing
	//--------------------------------------------------------------
	logic issue;
	assign issue = (state == CIT_IDLE) && dec_valid && !mem_wait;

	// next state: the owed lock cycles are the last busy cycles, so the
	// registered interlock flag stands for exactly that many cycles
	cit_state_t next_state;
	logic [7:0] next_remain;

	always_comb begin
		next_state  = state;
		next_remain = remain;
		if (!mem_wait) begin
			case (state)
				CIT_IDLE: begin
					if (issue && (next_cycles > 8'h1)) begin
						next_remain = next_cycles - 8'h1;
						next_state  = (next_lock != 8'h0 &&
							next_remain <= next_lock) ? CIT_LOCK : CIT_BUSY;
					end
				end
				CIT_BUSY, CIT_LOCK: begin
					next_remain = remain - 8'h1;
					if (remain == 8'h1) begin
						next_state = CIT_IDLE;
					end else if (lock_left != 8'h0 &&
						next_remain <= lock_left) begin
						next_state = CIT_LOCK;
					end else begin
						next_state = CIT_BUSY;
					end
				end
				default: begin
					next_state  = CIT_IDLE;
					next_remain = 8'h0;
				end
			endcase
		end
	end

	// main state and counters; memory wait freezes everything
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state     <= CIT_IDLE;
			remain    <= 8'h0;
			lock_left <= 8'h0;
		end else begin
			state  <= next_state;
			remain <= next_remain;
			if (issue) begin
				lock_left <= next_lock;
			end else if (next_state == CIT_IDLE) begin
				lock_left <= 8'h0;
			end
		end
	end

	// multiple transfer list walk, lowest register first
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			xfer_list  <= 16'h0;
			xfer_store <= 1'b0;
			xfer_first <= 1'b0;
		end else if (!mem_wait) begin
			if (issue && (dec_instr.op == CIT_MULTI_LOAD ||
				dec_instr.op == CIT_MULTI_STORE)) begin
				xfer_list  <= dec_instr.reg_list;
				xfer_store <= (dec_instr.op == CIT_MULTI_STORE);
				xfer_first <= 1'b1;
			end else if (xfer_list != 16'h0) begin
				xfer_list[cit_lowest(xfer_list)] <= 1'b0;
				xfer_first <= 1'b0;
			end
		end
	end

	//--------------------------------------------------------------
	// registered outputs
	//--------------------------------------------------------------
	logic next_hold;
	assign next_hold = mem_wait || (issue && next_cycles > 8'h1) ||
		(state != CIT_IDLE && remain > 8'h1);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dec_accept   <= 1'b0;
			fetch_en     <= 1'b0;
			interlock    <= 1'b0;
			exec_ctl     <= '0;
			instr_cycles <= 8'h0;
		end else begin
			dec_accept <= issue && !next_hold;
			interlock  <= (next_state == CIT_LOCK);
			fetch_en   <= !mem_wait && (next_state != CIT_LOCK);
			exec_ctl.ex_bubble <= (next_state == CIT_LOCK) ||
				mem_wait;
			exec_ctl.mem_req   <= (xfer_list != 16'h0) && !mem_wait;
			exec_ctl.mem_kind  <= (xfer_list == 16'h0) ? CIT_CYC_I :
				(xfer_first ? CIT_CYC_N : CIT_CYC_S);
			exec_ctl.xfer_reg  <= cit_lowest(xfer_list);
			if (issue) begin
				instr_cycles <= next_cycles;
			end
		end
	end
endmodule : cit_core_timing

// ---- rtl/cit_defines.svh ----
// cycle counts and field positions for the interlock and timing block
`ifndef CIT_DEFINES_SVH
`define CIT_DEFINES_SVH
`define CIT_DP_CYC        4'h1
`define CIT_DP_REGSH_CYC  4'h2
`define CIT_LD_CYC        4'h1
`define CIT_LD_USE_CYC    4'h2
`define CIT_LD_ROT_CYC    4'h3
`define CIT_LD_PC_CYC     4'h5
`define CIT_LDM1_CYC      4'h2
`define CIT_LDM_PC_EXTRA  4'h4
`define CIT_SWP_CYC       4'h2
`define CIT_SWP_USE_CYC   4'h3
`define CIT_BR_CYC        4'h3
`define CIT_MUL_BASE      4'h2
`define CIT_MULL_BASE     4'h3
`define CIT_MRC_USE_EXTRA 4'h1
`define CIT_MULREG_HI     11
`define CIT_MULREG_LO     8
`define CIT_MULREG_C_HI   2
`define CIT_MULREG_C_LO   0
`endif

// ---- rtl/cit_pkg.sv ----
// types for the core interlock and cycle timing block
package cit_pkg;
	// instruction class seen in decode
	typedef enum logic [3:0] {
		CIT_DATA_OP        = 4'h0,
		CIT_SINGLE_LOAD    = 4'h1,
		CIT_SINGLE_STORE   = 4'h2,
		CIT_MULTI_LOAD     = 4'h3,
		CIT_MULTI_STORE    = 4'h4,
		CIT_ATOMIC_SWAP    = 4'h5,
		CIT_BRANCH_OPS     = 4'h6,
		CIT_SOFTWARE_TRAP  = 4'h7,
		CIT_COPROC_DATA_OP = 4'h8,
		CIT_COPROC_LDST    = 4'h9,
		CIT_CORE_TO_COPROC = 4'hA,
		CIT_COPROC_TO_CORE = 4'hB,
		CIT_SHORT_MULTIPLY = 4'hC,
		CIT_SIGNED_LONG    = 4'hD,
		CIT_UNSIGNED_LONG  = 4'hE
	} cit_class_t;

	// data side cycle kind
	typedef enum logic [1:0] {
		CIT_CYC_I = 2'h0,
		CIT_CYC_N = 2'h1,
		CIT_CYC_S = 2'h2,
		CIT_CYC_C = 2'h3
	} cit_cyc_t;

	// decoded instruction presented by decode
	typedef struct packed {
		cit_class_t  op;
		logic        reg_shift;   // shift amount from a register
		logic        narrow;      // byte, halfword or unaligned word
		logic        dest_pc;     // writes the program counter
		logic        compressed;  // compressed encoding
		logic [31:0] instr;       // raw instruction word
		logic [15:0] reg_list;    // multiple transfer register list
		logic [3:0]  dest_reg;    // load, swap or coprocessor-to-core destination
		logic [4:0]  words;       // coprocessor transfer word count
		logic [3:0]  busy;        // coprocessor busy-wait cycles
	} cit_instr_t;

	// registers read by the following instruction
	typedef struct packed {
		logic        valid;
		logic [15:0] src_mask;
	} cit_next_t;

	// timing state shown to execute and memory
	typedef struct packed {
		logic       ex_bubble;
		logic       mem_req;
		cit_cyc_t   mem_kind;
		logic [3:0] xfer_reg;
	} cit_exec_t;
endpackage : cit_pkg

// ---- verif/cit_core_timing_monitor.sv ----
// assertion checker for the interlock and cycle timing block
`timescale 1ns/1ns
module cit_core_timing_monitor (
	// clock and reset
	input wire logic               sys_clk,
	input wire logic               srst,
	// decode side
	input wire logic               dec_valid,
	input wire cit_pkg::cit_instr_t dec_instr,
	input wire cit_pkg::cit_next_t  dec_next,
	input wire logic [31:0]        mul_operand,
	input wire logic               mem_wait,
	// control outputs
	input wire logic               dec_accept,
	input wire logic               fetch_en,
	input wire logic               interlock,
	input wire cit_pkg::cit_exec_t  exec_ctl,
	input wire logic [3:0]         mul_reg_sel,
	input wire logic [7:0]         instr_cycles
);
	import cit_pkg::*;
	logic is_ld;
	logic use_ld;
	// single load whose result the next instruction reads
	assign is_ld = dec_instr.op == CIT_SINGLE_LOAD && !dec_instr.dest_pc;
	assign use_ld = dec_next.valid && dec_next.src_mask[dec_instr.dest_reg];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	// an instruction taken after an idle decode cycle
	sequence s_issue;
		!dec_valid ##1 (dec_valid && !mem_wait);
	endsequence
	sequence s_lock1;
		interlock ##1 !interlock;
	endsequence
	sequence s_lock2;
		interlock [*2] ##1 !interlock;
	endsequence
	a_selreg_full: assert property (!dec_instr.compressed |->
		mul_reg_sel == dec_instr.instr[11:8]) else $error("mul reg select");
	a_selreg_comp: assert property (dec_instr.compressed |->
		mul_reg_sel == {1'b0, dec_instr.instr[2:0]}) else $error("c select");
	a_lock_nofetch: assert property (interlock |-> !fetch_en)
		else $error("fetch during interlock");
	a_dp_time: assert property (s_issue ##0 dec_instr.op == CIT_DATA_OP
		|=> instr_cycles == {7'h00, $past(dec_instr.reg_shift)} + 8'h01)
		else $error("data op cycles");
	a_ld_plain: assert property (s_issue ##0 (is_ld && !use_ld)
		|=> instr_cycles == 8'h01 && !interlock) else $error("load cycles");
	a_ld_use: assert property (s_issue ##0 (is_ld && use_ld &&
		!dec_instr.narrow) |=> (instr_cycles == 8'h02) ##0 s_lock1)
		else $error("load use interlock");
	a_ld_rotate: assert property (s_issue ##0 (is_ld && use_ld &&
		dec_instr.narrow) |=> (instr_cycles == 8'h03) ##0 s_lock2)
		else $error("narrow load interlock");
	a_ld_pc: assert property (s_issue ##0 (dec_instr.dest_pc &&
		dec_instr.op == CIT_SINGLE_LOAD) |=> instr_cycles == 8'h05)
		else $error("pc load cycles");
	a_mul_fast: assert property (s_issue ##0 (mul_operand[31:8] == 0 &&
		dec_instr.op == CIT_SHORT_MULTIPLY) |=> instr_cycles == 8'h03)
		else $error("short multiply cycles");
	a_lock_bubble: assert property (interlock |-> exec_ctl.ex_bubble)
		else $error("no bubble during interlock");
	a_xfer_first: assert property ($rose(exec_ctl.mem_req) |->
		exec_ctl.mem_kind == CIT_CYC_N) else $error("first transfer kind");
	a_ldm_single: assert property (s_issue ##0
		(dec_instr.op == CIT_MULTI_LOAD && $onehot(dec_instr.reg_list) &&
		!dec_instr.reg_list[15] && !(dec_next.valid &&
		|(dec_next.src_mask & dec_instr.reg_list)))
		|=> instr_cycles == 8'h02) else $error("one register load cycles");
endmodule : cit_core_timing_monitor

bind cit_core_timing cit_core_timing_monitor u_mon (.sys_clk(sys_clk),
	.srst(srst), .dec_valid(dec_valid), .dec_instr(dec_instr),
	.dec_next(dec_next), .mul_operand(mul_operand), .mem_wait(mem_wait),
	.dec_accept(dec_accept), .fetch_en(fetch_en), .interlock(interlock),
	.exec_ctl(exec_ctl), .mul_reg_sel(mul_reg_sel),
	.instr_cycles(instr_cycles));

// ---- verif/cit_mem_model.sv ----
// register file and cached memory model facing the timing block
`timescale 1ns/1ns
module cit_mem_model (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// register file port
	input  wire logic [3:0]  reg_sel,
	input  wire logic        wr_en,
	input  wire logic [3:0]  wr_idx,
	input  wire logic [31:0] wr_data,
	output logic [31:0]      rd_data,
	// miss control
	input  wire logic [3:0]  miss_len,
	output logic             mem_wait
);
	logic [31:0] regs [16];
	logic [3:0]  miss_cnt;
	// register file write, read is combinational
	always_ff @(posedge sys_clk) begin
		if (wr_en)
			regs[wr_idx] <= wr_data;
	end
	assign rd_data = regs[reg_sel];
	// uncached stretch lasts miss_len cycles, reloaded from miss_len whenever the count is zero
	always_ff @(posedge sys_clk) begin
		if (srst)
			miss_cnt <= 4'h0;
		else if (miss_cnt != 4'h0)
			miss_cnt <= miss_cnt - 4'h1;
		else
			miss_cnt <= miss_len;
	end
	assign mem_wait = miss_cnt != 4'h0;
endmodule : cit_mem_model

// ---- verif/core_interlock_cycle_timing_tb.sv ----
// self-checking testbench for the interlock and cycle timing block
`timescale 1ns/1ns
module core_interlock_cycle_timing_tb;
	import cit_pkg::*;
	logic        sys_clk = 1'b0;
	logic        srst, dec_valid, dec_accept, fetch_en, interlock, mem_wait;
	logic        wr_en, acc;
	logic [3:0]  wr_idx, miss_len, mul_reg_sel;
	logic [31:0] wr_data, mul_operand;
	logic [7:0]  instr_cycles, cyc;
	cit_instr_t  dec_instr, base;
	cit_next_t   dec_next;
	cit_exec_t   exec_ctl;
	int          mismatches, cmp_count, lk, bk, fk;
	cit_cyc_t    kq[$];
	logic [3:0]  rq[$];

	always #20 sys_clk = ~sys_clk;

	cit_core_timing DUT (.sys_clk(sys_clk), .srst(srst),
		.dec_valid(dec_valid), .dec_instr(dec_instr), .dec_next(dec_next),
		.mul_operand(mul_operand), .mem_wait(mem_wait),
		.dec_accept(dec_accept), .fetch_en(fetch_en), .interlock(interlock),
		.exec_ctl(exec_ctl), .mul_reg_sel(mul_reg_sel),
		.instr_cycles(instr_cycles));
	cit_mem_model u_mem (.sys_clk(sys_clk), .srst(srst),
		.reg_sel(mul_reg_sel), .wr_en(wr_en), .wr_idx(wr_idx),
		.wr_data(wr_data), .rd_data(mul_operand), .miss_len(miss_len),
		.mem_wait(mem_wait));

	// log data transfers and interlock cycles away from the edge
	always @(negedge sys_clk) begin
		if (exec_ctl.mem_req) begin
			kq.push_back(exec_ctl.mem_kind);
			rq.push_back(exec_ctl.xfer_reg);
		end
		if (interlock)
			lk++;
		if (exec_ctl.ex_bubble)
			bk++;
		if (!fetch_en)
			fk++;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic summarize;
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	// issue one instruction, record its cycle count, then idle
	task automatic go(input cit_class_t op, input logic [15:0] use_m);
		kq.delete();
		rq.delete();
		lk = 0;
		bk = 0;
		fk = 0;
		base.op = op;
		@(posedge sys_clk);
		dec_instr <= base;
		dec_next <= '{valid: use_m != 16'h0000, src_mask: use_m};
		dec_valid <= 1'b1;
		@(posedge sys_clk);
		dec_valid <= 1'b0;
		#1 cyc = instr_cycles;
		acc = dec_accept;
		repeat (14) @(posedge sys_clk);
	endtask : go

	task automatic xfer_chk(input int n, input logic [3:0] r0);
		check(kq.size(), n);
		foreach (kq[i]) begin
			check(kq[i], (i == 0) ? CIT_CYC_N : CIT_CYC_S);
			check(rq[i], r0 + i);
		end
	endtask : xfer_chk

	task automatic t_single;
		go(CIT_DATA_OP, 16'h0000);
		check(cyc, 8'h01);
		check(acc, 1'b1);
		base.reg_shift = 1'b1;
		go(CIT_DATA_OP, 16'h0000);
		check(cyc, 8'h02);
		base = '0;
		go(CIT_SINGLE_LOAD, 16'h0000);
		check({cyc, lk[7:0]}, 16'h0100);
		go(CIT_SINGLE_LOAD, 16'h0001);
		check({cyc, lk[7:0]}, 16'h0201);
		check(bk, 1);
		check(fk, 1);
		check(acc, 1'b0);
		base.narrow = 1'b1;
		go(CIT_SINGLE_LOAD, 16'h0001);
		check({cyc, lk[7:0]}, 16'h0302);
		check(bk, 2);
		check(fk, 2);
		go(CIT_ATOMIC_SWAP, 16'h0001);
		check(cyc, 8'h03);
		base = '0;
		go(CIT_ATOMIC_SWAP, 16'h0000);
		check(cyc, 8'h02);
		base.dest_pc = 1'b1;
		go(CIT_SINGLE_LOAD, 16'h0000);
		check(cyc, 8'h05);
	endtask : t_single

	task automatic t_multi;
		base = '0;
		base.reg_list = 16'h0002;
		go(CIT_MULTI_LOAD, 16'h0000);
		check(cyc, 8'h02);
		base.reg_list = 16'h800E;
		go(CIT_MULTI_LOAD, 16'h0000);
		check(cyc, 8'h08);
		base.reg_list = 16'h001E;
		go(CIT_MULTI_STORE, 16'h0000);
		check(cyc, 8'h04);
		xfer_chk(4, 4'h1);
		base.reg_list = 16'h000E;
		go(CIT_MULTI_LOAD, 16'h0002);
		check({cyc, lk[7:0]}, 16'h0300);
		xfer_chk(3, 4'h1);
		go(CIT_MULTI_LOAD, 16'h0008);
		check({cyc, lk[7:0]}, 16'h0401);
	endtask : t_multi

	task automatic t_copro;
		base = '0;
		base.busy = 4'h2;
		go(CIT_COPROC_TO_CORE, 16'h0000);
		check(cyc, 8'h03);
		go(CIT_COPROC_TO_CORE, 16'h0001);
		check(cyc, 8'h04);
		go(CIT_COPROC_DATA_OP, 16'h0000);
		check(cyc, 8'h03);
		base.words = 5'h03;
		go(CIT_COPROC_LDST, 16'h0000);
		check(cyc, 8'h05);
	endtask : t_copro

	// load register 5, then multiply with the selected register
	task automatic mulc(input cit_class_t op, input logic [31:0] v,
		input logic [7:0] exp);
		@(posedge sys_clk);
		wr_en <= 1'b1;
		wr_idx <= 4'h5;
		wr_data <= v;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		go(op, 16'h0000);
		check(cyc, exp);
	endtask : mulc

	task automatic t_mul;
		base = '0;
		base.instr = 32'h0000_0503;
		mulc(CIT_SHORT_MULTIPLY, 32'h0000007F, 8'h03);
		mulc(CIT_SHORT_MULTIPLY, 32'hFFFF8000, 8'h04);
		mulc(CIT_SHORT_MULTIPLY, 32'h00123456, 8'h05);
		mulc(CIT_SIGNED_LONG, 32'hFFFFFF80, 8'h04);
		mulc(CIT_UNSIGNED_LONG, 32'h0000FF00, 8'h05);
		mulc(CIT_UNSIGNED_LONG, 32'hFFFFFF80, 8'h07);
		base.compressed = 1'b1;
		mulc(CIT_SHORT_MULTIPLY, 32'h12345678, 8'h03);
	endtask : t_mul

	task automatic t_wait;
		@(posedge sys_clk);
		miss_len <= 4'h4;
		@(posedge sys_clk);
		miss_len <= 4'h0;
		repeat (2) @(posedge sys_clk);
		#1 check(fetch_en, 1'b0);
		repeat (8) @(posedge sys_clk);
		#1 check(fetch_en, 1'b1);
	endtask : t_wait

	// watchdog
	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		summarize();
	end

	initial begin
		srst = 1'b1;
		dec_valid = 1'b0;
		dec_instr = '0;
		dec_next = '0;
		base = '0;
		wr_en = 1'b0;
		wr_idx = 4'h0;
		wr_data = 32'h00000042;
		miss_len = 4'h0;
		repeat (3) @(posedge sys_clk);
		wr_idx <= 4'h3;
		wr_en <= 1'b1;
		srst <= 1'b0;
		t_single();
		t_multi();
		t_copro();
		t_mul();
		t_wait();
		summarize();
	end
endmodule : core_interlock_cycle_timing_tb
